// ===== design/sbc_codec.sv
// Serial link 8b/10b character codec: DWORD transmitter and character receiver.
// Assumes link layer and deserializer logic on clk; one character per cycle.
//
// Overview of operation
// RL1: Non-ALIGN primitive prefix is 001111 0011 at rd-, 110000 1100 at rd+.
// RL2: ALIGN prefix is 001111 1010 at rd-, 110000 0101 at rd+.
// RL3: Only the two control characters exist, only as byte 0 of primitives.
// RL4: Primitive characters follow normal running disparity between sub-blocks.
// RL5: Every control character inverts the running disparity.
// RL6: Disparity after a whole ALIGN equals disparity before it.
// RL7: Line order of a character is a b c d e i f g h j.
// RL8: DWORD bytes go out byte 0 first, byte 3 last.
// RL9: Frame DWORDs go out in the order the link layer offers them.
// RL10: Byte order and sub-block disparity match a byte-wide encoder.
// RL11: Receiver looks up characters in the current disparity column only.
// RL12: Characters not in that column are flagged as code violations.
// RL13: Receive disparity updates on every character, violations included.
// RL14: Receive disparity is tracked at the end of each sub-block.
// RL15: Same-polarity unbalanced sub-blocks in a row make a character invalid.
// RL16: A bit error may show up one or more characters later.
// RL17: Code violations and disparity errors are counted for firmware.
// RL18: Both disparity registers start negative after reset.
// RL19: Each decoded byte carries a control or data flag.
`include "sbc_defines.svh"

module sbc_codec (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire sbc_pkg::sbc_tx_req_t tx_req,
  output logic                     tx_ready,
  output sbc_pkg::sbc_sym_t        tx_sym,
  input  wire sbc_pkg::sbc_sym_t   rx_sym,
  output sbc_pkg::sbc_rx_t         rx_chr,
  output sbc_pkg::sbc_cnt_t        viol_cnt,
  output sbc_pkg::sbc_cnt_t        disp_cnt
);
  import sbc_pkg::*;

  sbc_state_t st_r;
  sbc_state_t st_nxt;

  logic [7:0] enc_byte;
  logic       enc_ctrl;
  logic [9:0] enc_sym;
  logic       enc_rd;
  logic       accept;

  // Saturating counter step
  function automatic sbc_cnt_t sat_inc(input sbc_cnt_t c, input logic hit);
    if (hit && (c != '1)) begin
      return c + sbc_cnt_t'(1);
    end
    return c;
  endfunction : sat_inc

  // Byte of the current DWORD, byte 0 first
  assign enc_byte = st_r.tx_dword[{st_r.tx_idx, 3'h0} +: 8]; // [RL8]
  assign enc_ctrl = st_r.tx_prim && (st_r.tx_idx == 2'h0); // [RL3]
  assign accept   = st_r.tx_ready && tx_req.valid;

  sbc_enc u_enc (
    .data   (enc_byte),
    .ctrl   (enc_ctrl),
    .rd_in  (st_r.tx_rd),
    .sym    (enc_sym),
    .rd_out (enc_rd)
  );

  always_comb begin
    logic [9:0] code;
    logic [5:0] s6;
    logic [3:0] s4;
    logic       rd_mid;
    logic       rd_end;
    logic       f6;
    logic       f4;
    logic [4:0] x;
    logic [2:0] y;
    logic       k3;
    logic       k5;
    logic       d_err;
    int         n6;
    int         n4;
    code   = sbc_wire_order(rx_sym.sym);
    s6     = code[9:4];
    s4     = code[3:0];
    rd_mid = sbc_rd6(s6, st_r.rx_rd); // [RL14]
    rd_end = sbc_rd4(s4, rd_mid); // [RL14]
    f6     = 1'b0;
    f4     = 1'b0;
    x      = 5'h00;
    y      = 3'h0;
    n6     = $countones(s6);
    n4     = $countones(s4);
    k3     = (code == (st_r.rx_rd ? `SBC_K283_POS : `SBC_K283_NEG));
    k5     = (code == (st_r.rx_rd ? `SBC_K285_POS : `SBC_K285_NEG));
    d_err  = 1'b0;
    st_nxt = st_r;

    // Transmit: one character per cycle, bytes in ascending order
    st_nxt.tx_out.valid = st_r.tx_busy;
    st_nxt.tx_out.sym   = '0;
    if (st_r.tx_busy) begin
      st_nxt.tx_out.sym     = enc_sym; // [RL10]
      st_nxt.tx_rd          = enc_rd; // [RL4]
      st_nxt.tx_out_idx     = st_r.tx_idx;
      st_nxt.tx_out_ctrl    = enc_ctrl;
      st_nxt.tx_out_align   = enc_ctrl && (enc_byte == `SBC_K285_BYTE); // [RL6]
      st_nxt.tx_out_rd_pre  = st_r.tx_rd;
      st_nxt.tx_idx         = st_r.tx_idx + 2'h1; // [RL8]
      if (st_r.tx_idx == `SBC_LAST_BYTE) begin
        st_nxt.tx_busy = 1'b0;
      end
    end
    // DWORDs are taken strictly in offered order, back to back
    if (accept) begin
      st_nxt.tx_busy  = 1'b1; // [RL9]
      st_nxt.tx_idx   = 2'h0;
      st_nxt.tx_dword = tx_req.dword;
      st_nxt.tx_prim  = tx_req.prim;
    end
    st_nxt.tx_ready = !st_nxt.tx_busy || (st_nxt.tx_idx == `SBC_LAST_BYTE);

    // Receive: column lookup against current disparity
    for (int i = 0; i < 32; i++) begin
      if (sbc_enc6(5'(i), st_r.rx_rd) == s6) begin
        f6 = 1'b1; // [RL11]
        x  = 5'(i);
      end
    end
    for (int j = 0; j < 8; j++) begin
      if (sbc_enc4(3'(j), rd_mid, x) == s4) begin
        f4 = 1'b1; // [RL11]
        y  = 3'(j);
      end
    end
    d_err = (n6 < 2) || (n6 > 4) || (n4 < 1) || (n4 > 3)
         || (st_r.rx_rd && (n6 > 3)) || (!st_r.rx_rd && (n6 < 3))
         || (rd_mid && (n4 > 2)) || (!rd_mid && (n4 < 2)); // [RL15]

    st_nxt.rx_out.valid    = rx_sym.valid;
    st_nxt.rx_out.ctrl     = 1'b0;
    st_nxt.rx_out.viol     = 1'b0;
    st_nxt.rx_out.disp_err = 1'b0;
    st_nxt.rx_out.data     = 8'h00;
    if (rx_sym.valid) begin
      if (k3 || k5) begin
        st_nxt.rx_out.ctrl = 1'b1; // [RL19]
        st_nxt.rx_out.data = k5 ? `SBC_K285_BYTE : `SBC_K283_BYTE;
      end else if (f6 && f4) begin
        st_nxt.rx_out.data = {y, x}; // [RL11]
      end else begin
        st_nxt.rx_out.viol = 1'b1; // [RL12]
      end
      st_nxt.rx_out.disp_err = d_err && !(k3 || k5);
      // Errored characters still move disparity, so detection may come later
      st_nxt.rx_rd           = rd_end; // [RL13] [RL16]
      // Error counts for link quality
      st_nxt.viol_cnt = sat_inc(st_r.viol_cnt, st_nxt.rx_out.viol); // [RL17]
      st_nxt.disp_cnt = sat_inc(st_r.disp_cnt, st_nxt.rx_out.disp_err); // [RL17]
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r          <= '0;
      st_r.tx_ready <= 1'b1;
      st_r.tx_rd    <= `SBC_RD_RESET; // [RL18]
      st_r.rx_rd    <= `SBC_RD_RESET; // [RL18]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tx_ready = st_r.tx_ready;
  assign tx_sym   = st_r.tx_out;
  assign rx_chr   = st_r.rx_out;
  assign viol_cnt = st_r.viol_cnt;
  assign disp_cnt = st_r.disp_cnt;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_prim_taken;
    tx_ready && tx_req.valid && tx_req.prim
      && (tx_req.dword[7:0] != `SBC_K285_BYTE);
  endsequence

  sequence s_align_taken;
    tx_ready && tx_req.valid && tx_req.prim
      && (tx_req.dword[7:0] == `SBC_K285_BYTE);
  endsequence

  sequence s_dword_out;
    tx_sym.valid && (st_r.tx_out_idx == 2'h0) ##1
    tx_sym.valid && (st_r.tx_out_idx == 2'h1) ##1
    tx_sym.valid && (st_r.tx_out_idx == 2'h2) ##1
    tx_sym.valid && (st_r.tx_out_idx == 2'h3);
  endsequence

  a_prefix_code: assert property ( // [RL1]
    s_prim_taken |-> ##2 st_r.tx_out_ctrl
      && ((tx_sym.sym == sbc_wire_order(`SBC_K283_NEG)) && !st_r.tx_out_rd_pre
       || (tx_sym.sym == sbc_wire_order(`SBC_K283_POS)) && st_r.tx_out_rd_pre))
    else $error("primitive prefix code wrong");

  a_comma_code: assert property ( // [RL2]
    s_align_taken |-> ##2 st_r.tx_out_align
      && ((tx_sym.sym == sbc_wire_order(`SBC_K285_NEG)) && !st_r.tx_out_rd_pre
       || (tx_sym.sym == sbc_wire_order(`SBC_K285_POS)) && st_r.tx_out_rd_pre))
    else $error("comma code wrong");

  a_ctrl_byte_zero: assert property ( // [RL3]
    tx_sym.valid && st_r.tx_out_ctrl |-> st_r.tx_out_idx == 2'h0)
    else $error("control character outside byte 0");

  a_ctrl_flips_rd: assert property ( // [RL5]
    tx_sym.valid && st_r.tx_out_ctrl |-> st_r.tx_rd != st_r.tx_out_rd_pre)
    else $error("control character kept disparity");

  a_align_neutral: assert property ( // [RL6]
    (tx_sym.valid && st_r.tx_out_align) ##1 tx_sym.valid [*3]
      |-> st_r.tx_rd == $past(st_r.tx_out_rd_pre, 3))
    else $error("align changed disparity");

  a_byte_order: assert property ( // [RL8]
    tx_ready && tx_req.valid |-> ##2 s_dword_out)
    else $error("dword bytes out of order");

  a_rx_bad_weight: assert property ( // [RL12]
    rx_sym.valid && (($countones(rx_sym.sym[5:0]) < 2)
      || ($countones(rx_sym.sym[5:0]) > 4))
      |=> rx_chr.valid && rx_chr.viol && !rx_chr.ctrl)
    else $error("unbalanced character not flagged");

  a_rx_rd_track: assert property ( // [RL13]
    rx_sym.valid && ($countones(rx_sym.sym[5:0]) == 4)
      && ($countones(rx_sym.sym[9:6]) == 2)
      && (rx_sym.sym[9:6] != 4'h3) && (rx_sym.sym[9:6] != 4'hc)
      |=> st_r.rx_rd == `SBC_RD_POS)
    else $error("receive disparity not updated");

  a_rx_comma: assert property ( // [RL19]
    rx_sym.valid && (st_r.rx_rd == `SBC_RD_NEG)
      && (rx_sym.sym == sbc_wire_order(`SBC_K285_NEG))
      |=> rx_chr.ctrl && !rx_chr.viol && (rx_chr.data == `SBC_K285_BYTE)
      && (st_r.rx_rd == `SBC_RD_POS))
    else $error("comma not decoded as control");

  a_rx_same_sign: assert property ( // [RL15]
    rx_sym.valid && (st_r.rx_rd == `SBC_RD_POS)
      && ($countones(rx_sym.sym[5:0]) == 4)
      |=> rx_chr.viol && rx_chr.disp_err)
    else $error("same polarity sub-block accepted");

  a_viol_count: assert property ( // [RL17]
    rx_chr.valid && rx_chr.viol && ($past(viol_cnt) != '1)
      |-> viol_cnt == $past(viol_cnt) + sbc_cnt_t'(1))
    else $error("violation not counted");

endmodule : sbc_codec

// ===== design/sbc_defines.svh
// Constants of the serial 8b/10b character codec.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// Control characters, abcdei fghj with bit a in the top position
`define SBC_K283_NEG  10'h0f3
`define SBC_K283_POS  10'h30c
`define SBC_K285_NEG  10'h0fa
`define SBC_K285_POS  10'h305

// Byte values carried by the control characters
`define SBC_K283_BYTE 8'h7c
`define SBC_K285_BYTE 8'hbc

// Running disparity encoding and reset value
`define SBC_RD_NEG    1'b0
`define SBC_RD_POS    1'b1
`define SBC_RD_RESET  1'b0

// Last byte index of a DWORD and width of the quality counters
`define SBC_LAST_BYTE 2'h3
`define SBC_CNT_W     16

`endif

// ===== design/sbc_enc.sv
// One-character 8b/10b encoder with running disparity in and out.
// Assumes the caller holds the disparity register and picks control bytes.
`include "sbc_defines.svh"

module sbc_enc (
  input  wire logic [7:0] data,
  input  wire logic       ctrl,
  input  wire logic       rd_in,
  output logic      [9:0] sym,
  output logic            rd_out
);
  import sbc_pkg::*;

  logic [5:0] s6;
  logic [3:0] s4;
  logic       rd_mid;
  logic [9:0] code;

  always_comb begin
    s6     = sbc_enc6(data[4:0], rd_in);
    rd_mid = sbc_rd6(s6, rd_in);
    s4     = sbc_enc4(data[7:5], rd_mid, data[4:0]);
    if (ctrl) begin
      if (data == `SBC_K285_BYTE) begin
        code = rd_in ? `SBC_K285_POS : `SBC_K285_NEG; // [RL2]
      end else begin
        code = rd_in ? `SBC_K283_POS : `SBC_K283_NEG; // [RL1]
      end
      rd_out = ~rd_in; // [RL5]
    end else begin
      code   = {s6, s4};
      rd_out = sbc_rd4(s4, rd_mid); // [RL4]
    end
    sym = sbc_wire_order(code); // [RL7]
  end

endmodule : sbc_enc

// ===== design/sbc_pkg.sv
// Types, code tables and code functions of the 8b/10b character codec.
// Assumes sbc_defines.svh is on the include path.
`include "sbc_defines.svh"

package sbc_pkg;

  typedef logic [`SBC_CNT_W-1:0] sbc_cnt_t;

  // Transmit request: one DWORD, byte 0 in bits 7:0
  typedef struct packed {
    logic        valid;
    logic        prim;
    logic [31:0] dword;
  } sbc_tx_req_t;

  // Encoded character, bit 0 is the first bit on the line
  typedef struct packed {
    logic       valid;
    logic [9:0] sym;
  } sbc_sym_t;

  // Decoded character towards the link layer
  typedef struct packed {
    logic       valid;
    logic       ctrl;
    logic       viol;
    logic       disp_err;
    logic [7:0] data;
  } sbc_rx_t;

  typedef struct packed {
    logic        tx_busy;
    logic [1:0]  tx_idx;
    logic [31:0] tx_dword;
    logic        tx_prim;
    logic        tx_rd;
    logic        tx_ready;
    sbc_sym_t    tx_out;
    logic [1:0]  tx_out_idx;
    logic        tx_out_ctrl;
    logic        tx_out_align;
    logic        tx_out_rd_pre;
    logic        rx_rd;
    sbc_rx_t     rx_out;
    sbc_cnt_t    viol_cnt;
    sbc_cnt_t    disp_cnt;
  } sbc_state_t;

  // 6b codes in the negative disparity column
  localparam logic [5:0] SBC_T6 [0:31] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};

  // 4b codes in the negative disparity column, and the alternate 7
  localparam logic [3:0] SBC_T4 [0:7] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] SBC_A7 = 4'h7;

  function automatic logic [5:0] sbc_enc6(input logic [4:0] x, input logic rd);
    logic [5:0] s;
    s = SBC_T6[x];
    if (rd && (($countones(s) != 3) || (x == 5'h07))) begin
      s = ~s;
    end
    return s;
  endfunction : sbc_enc6

  function automatic logic [3:0] sbc_enc4(input logic [2:0] y, input logic rd,
                                          input logic [4:0] x);
    logic [3:0] f;
    logic       alt;
    alt = rd ? (x == 5'h0b || x == 5'h0d || x == 5'h0e)
             : (x == 5'h11 || x == 5'h12 || x == 5'h14);
    f = (y == 3'h7 && alt) ? SBC_A7 : SBC_T4[y];
    if (rd && (($countones(f) != 2) || (y == 3'h3))) begin
      f = ~f;
    end
    return f;
  endfunction : sbc_enc4

  // Disparity at the end of a 6b sub-block
  function automatic logic sbc_rd6(input logic [5:0] s, input logic rd);
    int n;
    n = $countones(s);
    if (n > 3) return `SBC_RD_POS;
    if (n < 3) return `SBC_RD_NEG;
    if (s == 6'h07) return `SBC_RD_POS;
    if (s == 6'h38) return `SBC_RD_NEG;
    return rd;
  endfunction : sbc_rd6

  // Disparity at the end of a 4b sub-block
  function automatic logic sbc_rd4(input logic [3:0] f, input logic rd);
    int n;
    n = $countones(f);
    if (n > 2) return `SBC_RD_POS;
    if (n < 2) return `SBC_RD_NEG;
    if (f == 4'h3) return `SBC_RD_POS;
    if (f == 4'hc) return `SBC_RD_NEG;
    return rd;
  endfunction : sbc_rd4

  // Swaps between table order (a on top) and line order (a in bit 0)
  function automatic logic [9:0] sbc_wire_order(input logic [9:0] c);
    logic [9:0] w;
    w = '0;
    for (int i = 0; i < 10; i++) begin
      w[i] = c[9-i];
    end
    return w;
  endfunction : sbc_wire_order

endpackage : sbc_pkg

// ===== tb/sbc_far_end.sv
// Far-end model: remote transceiver that loops transmitted characters back.
// Assumes the bench drives inj on clk by non-blocking assignment; inj wins when valid.
module sbc_far_end (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire sbc_pkg::sbc_sym_t tx_sym,
  input  wire sbc_pkg::sbc_sym_t inj,
  output sbc_pkg::sbc_sym_t      rx_sym
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbc_pkg::*;

  sbc_sym_t src;

  // Injected characters may carry bit errors on purpose
  assign src = inj.valid ? inj : tx_sym;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_sym <= '0;
    end else begin
      rx_sym.valid <= src.valid;
      // Line order kept as sent; idle line does not hold the last character
      rx_sym.sym   <= src.valid ? src.sym : ~rx_sym.sym;
    end
  end
endmodule : sbc_far_end

// ===== tb/tb_top.sv
// Testbench of the 8b/10b character codec, far end looped back through a model.
// Assumes the design package and the far-end model are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sbc_pkg::*;

  logic        clk;
  logic        sys_rst;
  sbc_tx_req_t tx_req;
  logic        tx_ready;
  sbc_sym_t    tx_sym;
  sbc_sym_t    rx_sym;
  sbc_sym_t    inj;
  sbc_rx_t     rx_chr;
  sbc_cnt_t    viol_cnt;
  sbc_cnt_t    disp_cnt;
  int          n_errors;
  int          n_checks;
  int          cyc = 0;
  logic [9:0]  txq[$];
  sbc_rx_t     rxq[$];

  // Stream: prim, ALIGN at rd-, data, ALIGN at rd+, prim at rd+
  localparam logic [31:0] DW [5] = '{32'hb7354a7c, 32'hb74a4abc, 32'h1597b7c0,
                                     32'hc04a4abc, 32'h4a4a4a00};
  localparam logic [4:0]  PRIM   = 5'b11011;
  // Expected characters, table order with bit a on top
  localparam logic [9:0]  SYM [20] = '{10'h0f3, 10'h155, 10'h2a9, 10'h05a,
                                       10'h0fa, 10'h155, 10'h155, 10'h05a,
                                       10'h276, 10'h05a, 10'h3a2, 10'h2ab,
                                       10'h305, 10'h155, 10'h155, 10'h276,
                                       10'h30c, 10'h155, 10'h155, 10'h155};
  // Two single-bit-error streams, detection one and two characters late
  localparam logic [9:0]  INJ [7]   = '{10'h2ab, 10'h155, 10'h3aa, 10'h05a,
                                        10'h2ab, 10'h3a2, 10'h3aa};
  localparam logic [7:0]  INJ_D [7] = '{8'h15, 8'h4a, 8'h00, 8'hb7, 8'h15, 8'h00, 8'hb7};
  localparam logic [6:0]  INJ_V     = 7'b0100100;

  sbc_codec sbc_codec_i (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .tx_req   (tx_req),
    .tx_ready (tx_ready),
    .tx_sym   (tx_sym),
    .rx_sym   (rx_sym),
    .rx_chr   (rx_chr),
    .viol_cnt (viol_cnt),
    .disp_cnt (disp_cnt)
  );

  sbc_far_end sbc_far_end_i (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tx_sym  (tx_sym),
    .inj     (inj),
    .rx_sym  (rx_sym)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Collect characters where outputs are settled
  always @(negedge clk) begin
    if (tx_sym.valid === 1'b1) txq.push_back(tx_sym.sym);
    if (rx_chr.valid === 1'b1) rxq.push_back(rx_chr);
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      stop_test();
    end
  end

  function automatic logic [9:0] line_of(input logic [9:0] t);
    logic [9:0] r;
    for (int i = 0; i < 10; i++) r[i] = t[9-i];
    return r;
  endfunction : line_of

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic test_reset;
    @(negedge clk);
    check({31'h0, tx_ready}, 32'h1);
    check({31'h0, tx_sym.valid}, 32'h0);
    check({20'h0, rx_chr}, 32'h0);
    check({viol_cnt, disp_cnt}, 32'h0);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_tx_stream;
    logic [7:0] b;
    logic       c;
    txq.delete();
    rxq.delete();
    for (int d = 0; d < 5; d++) begin
      tx_req <= '{valid: 1'b1, prim: PRIM[d], dword: DW[d]};
      @(negedge clk);
      while (tx_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    tx_req <= '0;
    repeat (8) @(posedge clk);
    check(32'(txq.size()), 32'd20);
    for (int k = 0; k < txq.size() && k < 20; k++) begin
      check({22'h0, txq[k]}, {22'h0, line_of(SYM[k])});
    end
    check(32'(rxq.size()), 32'd20);
    for (int k = 0; k < rxq.size() && k < 20; k++) begin
      b = DW[k/4][8*(k%4) +: 8];
      c = PRIM[k/4] && (k % 4 == 0);
      if (c) b = (b == 8'hbc) ? 8'hbc : 8'h7c;
      check({22'h0, rxq[k].ctrl, rxq[k].viol, rxq[k].data}, {22'h0, c, 1'b0, b});
    end
    $display("test_tx_stream done");
  endtask : test_tx_stream

  task automatic test_rx_errors;
    rxq.delete();
    for (int k = 0; k < 7; k++) begin
      inj <= '{valid: 1'b1, sym: line_of(INJ[k])};
      @(posedge clk);
    end
    inj <= '0;
    repeat (4) @(posedge clk);
    check(32'(rxq.size()), 32'd7);
    for (int k = 0; k < rxq.size() && k < 7; k++) begin
      check({23'h0, rxq[k].viol, rxq[k].data}, {23'h0, INJ_V[k], INJ_D[k]});
    end
    check({16'h0, viol_cnt}, 32'h2);
    check({16'h0, disp_cnt}, 32'h2);
    $display("test_rx_errors done");
  endtask : test_rx_errors

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    sys_rst  = 1'b1;
    tx_req   = '0;
    inj      = '0;
    n_errors = 0;
    n_checks = 0;
    test_reset();
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    test_tx_stream();
    test_rx_errors();
    stop_test();
  end
endmodule : tb_top
